// *** hw/exc_unit_pkg.sv ***
package exc_unit_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] REG_SR = 8'h00;
   localparam logic [7:0] REG_VTB = 8'h04;
   localparam logic [7:0] REG_MSTK = 8'h08;
   localparam logic [7:0] REG_ISTK = 8'h0C;
   localparam logic [7:0] REG_PC = 8'h10;
   localparam logic [7:0] REG_EVT = 8'h14;
   localparam logic [7:0] REG_MASK = 8'h18;
   localparam logic [7:0] REG_STATE = 8'h1C;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // status register fields
   localparam int SR_TRH_BIT = 15;
   localparam int SR_TRL_BIT = 14;
   localparam int SR_S_BIT = 13;
   localparam int SR_M_BIT = 12;
   localparam int SR_IPM_LSB = 8;
   localparam logic [15:0] SR_RESET = 16'h2700;
   localparam logic [2:0] IPM_ALL = 3'h7;
   // ==========================================================
   // event bits
   localparam int EVT_DONE = 0;
   localparam int EVT_IRQ = 1;
   localparam int EVT_HALT = 2;
   localparam int EVT_W = 3;
   // ==========================================================
   // exception processing
   typedef enum logic [1:0] {KIND_RESET, KIND_IRQ, KIND_INTERNAL, KIND_COPROC} exc_kind_type;
   typedef enum logic [2:0] {ST_IDLE, ST_IACK, ST_FRAME, ST_COPY, ST_VEC, ST_HALT} exc_state_type;
   localparam logic [4:0] FRAME_SHORT = 5'h04;
   localparam logic [4:0] FRAME_SIX = 5'h06;
   localparam logic [4:0] FRAME_MID = 5'h0A;
   localparam logic [4:0] FRAME_LONG = 5'h10;
   localparam logic [2:0] FC_SUPER_DATA = 3'h5;
   localparam logic [2:0] FC_CPU_SPACE = 3'h7;
   localparam logic [27:0] IACK_ADDR_HI = 28'hFFFFFFF;
   localparam logic [7:0] RESET_VECTOR = 8'h00;
   localparam logic [7:0] SPURIOUS_VECTOR = 8'h18;
   localparam logic [7:0] AUTOVEC_BASE = 8'h18;
endpackage : exc_unit_pkg

// *** hw/axil_reg_slave.sv ***
module axil_reg_slave
   import exc_unit_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [7:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [7:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   output logic wr_en_o,
   output logic [7:0] wr_addr_o,
   output logic [31:0] wr_data_o,
   output logic [3:0] wr_strb_o,
   input wire logic wr_ok_i,
   output logic rd_en_o,
   output logic [7:0] rd_addr_o,
   input wire logic [31:0] rd_data_i,
   input wire logic rd_ok_i
);
   typedef struct packed {
      logic have_aw;
      logic have_w;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } slave_state_type;

   slave_state_type s, next_s;

   assign awready_o = !s.have_aw && !s.bvalid;
   assign wready_o = !s.have_w && !s.bvalid;
   assign arready_o = !s.rvalid;
   assign wr_en_o = s.have_aw && s.have_w && !s.bvalid;
   assign wr_addr_o = s.awaddr;
   assign wr_data_o = s.wdata;
   assign wr_strb_o = s.wstrb;
   assign rd_en_o = arvalid_i && !s.rvalid;
   assign rd_addr_o = araddr_i;
   assign bvalid_o = s.bvalid;
   assign bresp_o = s.bresp;
   assign rvalid_o = s.rvalid;
   assign rdata_o = s.rdata;
   assign rresp_o = s.rresp;

   always_comb begin
      next_s = s;
      if (awvalid_i && awready_o) begin
         next_s.have_aw = 1'b1;
         next_s.awaddr = awaddr_i;
      end
      if (wvalid_i && wready_o) begin
         next_s.have_w = 1'b1;
         next_s.wdata = wdata_i;
         next_s.wstrb = wstrb_i;
      end
      if (wr_en_o) begin
         next_s.have_aw = 1'b0;
         next_s.have_w = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = wr_ok_i ? RESP_OKAY : RESP_SLVERR;
      end
      if (s.bvalid && bready_i) begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && rready_i) begin
         next_s.rvalid = 1'b0;
      end
      if (rd_en_o) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = rd_ok_i ? rd_data_i : 32'h00000000;
         next_s.rresp = rd_ok_i ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule : axil_reg_slave

// *** hw/exception_stacking_vectoring.sv ***
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
module exception_stacking_vectoring
   import exc_unit_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic [7:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [7:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   input wire logic exc_req_i,
   input wire logic [1:0] exc_kind_i,
   input wire logic [7:0] exc_vector_i,
   input wire logic [1:0] exc_point_i,
   input wire logic [31:0] exc_pc_i,
   output logic exc_busy_o,
   input wire logic [2:0] irq_level_inputs_i,
   input wire logic auto_vector_request_i,
   output logic irq_waiting_flag_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic mem_long_o,
   output logic [2:0] mem_fc_o,
   output logic [31:0] mem_addr_o,
   output logic [15:0] mem_wdata_o,
   input wire logic [31:0] mem_rdata_i,
   input wire logic mem_ack_i,
   input wire logic mem_err_i,
   input wire logic insn_boundary_i,
   output logic [31:0] new_pc_o,
   output logic new_pc_valid_o,
   output logic status_o,
   output logic refill_o,
   output logic irq_o
);
   // ==========================================================
   // state
   typedef struct packed {
      exc_state_type st;
      logic [15:0] sr;
      logic [15:0] sr_copy;
      logic [31:0] vtb;
      logic [31:0] master_stack_pointer;
      logic [31:0] irq_stack_pointer;
      logic [31:0] pc;
      logic [31:0] exc_pc;
      exc_kind_type kind;
      logic [1:0] point;
      logic [7:0] vec;
      logic [4:0] nwords;
      logic [4:0] idx;
      logic from_master;
      logic pend;
      logic [2:0] level;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] mask;
      logic req;
      logic we;
      logic long_acc;
      logic [2:0] fc;
      logic [31:0] addr;
      logic [15:0] wdata;
      logic new_pc_valid;
      logic status;
      logic refill;
   } core_state_type;

   core_state_type s, next_s;

   logic wr_en, wr_ok, rd_en, rd_ok;
   logic [7:0] wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data, cur_sp, frame_addr, copy_addr;
   logic [3:0] wr_strb;
   logic [2:0] cur_ipm;
   logic irq_seen;
   logic [EVT_W-1:0] evt_set;

   // ==========================================================
   // helpers
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'h0) && (a <= REG_STATE);
   endfunction : addr_ok

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                         input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         merge[b*8 +: 8] = strb[b] ? nv[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction : merge

   function automatic logic [4:0] frame_words(input exc_kind_type k, input logic [1:0] p);
      if (k == KIND_IRQ) begin
         frame_words = FRAME_SHORT;
      end else begin
         case (p)
            2'h0: frame_words = FRAME_SHORT;
            2'h1: frame_words = FRAME_SIX;
            2'h2: frame_words = FRAME_MID;
            default: frame_words = FRAME_LONG;
         endcase
      end
   endfunction : frame_words

   function automatic logic [15:0] frame_word(input core_state_type c, input logic [4:0] i);
      case (i)
         5'h00: frame_word = c.sr_copy;
         5'h01: frame_word = c.exc_pc[31:16];
         5'h02: frame_word = c.exc_pc[15:0];
         5'h03: frame_word = {2'h0, c.point, 2'h0, c.vec, 2'h0};
         default: frame_word = 16'h0000;
      endcase
   endfunction : frame_word

   // ==========================================================
   // register bus
   axil_reg_slave i_axil_reg_slave (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .awaddr_i(awaddr_i),
      .awvalid_i(awvalid_i),
      .awready_o(awready_o),
      .wdata_i(wdata_i),
      .wstrb_i(wstrb_i),
      .wvalid_i(wvalid_i),
      .wready_o(wready_o),
      .bresp_o(bresp_o),
      .bvalid_o(bvalid_o),
      .bready_i(bready_i),
      .araddr_i(araddr_i),
      .arvalid_i(arvalid_i),
      .arready_o(arready_o),
      .rdata_o(rdata_o),
      .rresp_o(rresp_o),
      .rvalid_o(rvalid_o),
      .rready_i(rready_i),
      .wr_en_o(wr_en),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .wr_strb_o(wr_strb),
      .wr_ok_i(wr_ok),
      .rd_en_o(rd_en),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .rd_ok_i(rd_ok)
   );

   assign wr_ok = addr_ok(wr_addr);
   assign rd_ok = addr_ok(rd_addr);

   always_comb begin
      case (rd_addr)
         REG_SR: rd_data = {16'h0000, s.sr};
         REG_VTB: rd_data = s.vtb;
         REG_MSTK: rd_data = s.master_stack_pointer;
         REG_ISTK: rd_data = s.irq_stack_pointer;
         REG_PC: rd_data = s.pc;
         REG_EVT: rd_data = {29'h0, s.evt};
         REG_MASK: rd_data = {29'h0, s.mask};
         REG_STATE: rd_data = {16'h0, s.vec, s.level, 2'h0, s.st};
         default: rd_data = 32'h00000000;
      endcase
   end

   // ==========================================================
   // outputs
   assign exc_busy_o = (s.st != ST_IDLE);
   assign irq_waiting_flag_o = s.pend;
   assign mem_req_o = s.req;
   assign mem_we_o = s.we;
   assign mem_long_o = s.long_acc;
   assign mem_fc_o = s.fc;
   assign mem_addr_o = s.addr;
   assign mem_wdata_o = s.wdata;
   assign new_pc_o = s.pc;
   assign new_pc_valid_o = s.new_pc_valid;
   assign status_o = s.status;
   assign refill_o = s.refill;
   assign irq_o = |(s.evt & s.mask);

   // ==========================================================
   // exception sequencer
   assign cur_ipm = s.sr[SR_IPM_LSB +: 3];
   // level 7 is taken even against a full mask
   assign irq_seen = (irq_level_inputs_i > cur_ipm) || (irq_level_inputs_i == IPM_ALL);
   assign cur_sp = s.from_master ? s.master_stack_pointer : s.irq_stack_pointer;
   assign frame_addr = cur_sp - {26'h0, s.nwords, 1'b0} + {26'h0, s.idx, 1'b0};
   assign copy_addr = s.irq_stack_pointer - {26'h0, FRAME_SHORT, 1'b0} + {26'h0, s.idx, 1'b0};

   always_comb begin
      next_s = s;
      evt_set = '0;
      next_s.new_pc_valid = 1'b0;
      next_s.refill = 1'b0;
      next_s.status = 1'b0;
      if (wr_en && wr_ok) begin
         case (wr_addr)
            REG_SR: next_s.sr = 16'(merge({16'h0, s.sr}, wr_data, wr_strb));
            REG_VTB: next_s.vtb = merge(s.vtb, wr_data, wr_strb);
            REG_MSTK: next_s.master_stack_pointer =
               merge(s.master_stack_pointer, wr_data, wr_strb);
            REG_ISTK: next_s.irq_stack_pointer = merge(s.irq_stack_pointer, wr_data, wr_strb);
            REG_EVT: next_s.evt = s.evt & ~wr_data[EVT_W-1:0];
            REG_MASK: next_s.mask = wr_data[EVT_W-1:0];
            default: next_s.mask = s.mask;
         endcase
      end
      next_s.pend = irq_seen;
      case (s.st)
         ST_IDLE: begin
            next_s.status = insn_boundary_i;
            if ((exc_req_i && exc_kind_i == KIND_RESET) || irq_seen || exc_req_i) begin
               if (exc_req_i && exc_kind_i == KIND_RESET) begin
                  next_s.kind = KIND_RESET;
               end else if (irq_seen) begin
                  next_s.kind = KIND_IRQ;
               end else begin
                  next_s.kind = exc_kind_type'(exc_kind_i);
               end
               next_s.sr_copy = s.sr;
               next_s.sr[SR_S_BIT] = 1'b1;
               next_s.sr[SR_TRH_BIT] = 1'b0;
               next_s.sr[SR_TRL_BIT] = 1'b0;
               next_s.exc_pc = exc_pc_i;
               next_s.point = exc_point_i;
               next_s.nwords = frame_words(next_s.kind, exc_point_i);
               next_s.from_master = s.sr[SR_M_BIT];
               next_s.idx = 5'h00;
               next_s.status = 1'b1;
               case (next_s.kind)
                  KIND_RESET: begin
                     next_s.sr[SR_IPM_LSB +: 3] = IPM_ALL;
                     next_s.sr[SR_M_BIT] = 1'b0;
                     next_s.vec = RESET_VECTOR;
                     next_s.st = ST_VEC;
                  end
                  KIND_IRQ: begin
                     next_s.level = irq_level_inputs_i;
                     next_s.sr[SR_IPM_LSB +: 3] = irq_level_inputs_i;
                     next_s.pend = 1'b1;
                     evt_set[EVT_IRQ] = 1'b1;
                     next_s.st = ST_IACK;
                  end
                  default: begin
                     next_s.vec = exc_vector_i;
                     next_s.st = ST_FRAME;
                  end
               endcase
            end
         end
         ST_IACK: begin
            // still waiting until the acknowledge cycle ends
            next_s.pend = !(s.req && (mem_ack_i || mem_err_i));
            if (!s.req) begin
               next_s.req = 1'b1;
               next_s.we = 1'b0;
               next_s.long_acc = 1'b0;
               next_s.fc = FC_CPU_SPACE;
               next_s.addr = {IACK_ADDR_HI, s.level, 1'b1};
            end else if (mem_ack_i || mem_err_i) begin
               next_s.req = 1'b0;
               if (mem_err_i) begin
                  next_s.vec = SPURIOUS_VECTOR;
               end else if (auto_vector_request_i) begin
                  next_s.vec = AUTOVEC_BASE + {5'h00, s.level};
               end else begin
                  next_s.vec = mem_rdata_i[7:0];
               end
               next_s.st = ST_FRAME;
            end
         end
         ST_FRAME: begin
            if (!s.req) begin
               next_s.req = 1'b1;
               next_s.we = 1'b1;
               next_s.long_acc = 1'b0;
               next_s.fc = FC_SUPER_DATA;
               next_s.addr = frame_addr;
               next_s.wdata = frame_word(s, s.idx);
            end else if (mem_err_i) begin
               next_s.req = 1'b0;
               next_s.st = ST_HALT;
            end else if (mem_ack_i) begin
               next_s.req = 1'b0;
               next_s.idx = s.idx + 5'h01;
               if (s.idx == s.nwords - 5'h01) begin
                  next_s.idx = 5'h00;
                  if (s.from_master) begin
                     next_s.master_stack_pointer = frame_addr - {26'h0, s.idx, 1'b0};
                  end else begin
                     next_s.irq_stack_pointer = frame_addr - {26'h0, s.idx, 1'b0};
                  end
                  if (s.kind == KIND_IRQ && s.from_master) begin
                     next_s.sr[SR_M_BIT] = 1'b0;
                     next_s.st = ST_COPY;
                  end else begin
                     next_s.st = ST_VEC;
                  end
               end
            end
         end
         ST_COPY: begin
            if (!s.req) begin
               next_s.req = 1'b1;
               next_s.we = 1'b1;
               next_s.long_acc = 1'b0;
               next_s.fc = FC_SUPER_DATA;
               next_s.addr = copy_addr;
               next_s.wdata = frame_word(s, s.idx);
            end else if (mem_err_i) begin
               next_s.req = 1'b0;
               next_s.st = ST_HALT;
            end else if (mem_ack_i) begin
               next_s.req = 1'b0;
               next_s.idx = s.idx + 5'h01;
               if (s.idx == FRAME_SHORT - 5'h01) begin
                  next_s.irq_stack_pointer = copy_addr - {26'h0, s.idx, 1'b0};
                  next_s.st = ST_VEC;
               end
            end
         end
         ST_VEC: begin
            if (!s.req) begin
               next_s.req = 1'b1;
               next_s.we = 1'b0;
               next_s.long_acc = 1'b1;
               next_s.fc = FC_SUPER_DATA;
               next_s.addr = s.vtb + {22'h0, s.vec, 2'h0};
            end else if (mem_err_i) begin
               next_s.req = 1'b0;
               next_s.st = ST_HALT;
            end else if (mem_ack_i) begin
               next_s.req = 1'b0;
               next_s.pc = mem_rdata_i;
               next_s.new_pc_valid = 1'b1;
               next_s.refill = 1'b1;
               evt_set[EVT_DONE] = 1'b1;
               next_s.st = ST_IDLE;
            end
         end
         ST_HALT: begin
            // fault while stacking or fetching the vector: sequencer stops until reset
            next_s.status = 1'b1;
            evt_set[EVT_HALT] = 1'b1;
         end
         default: begin
            next_s.st = ST_IDLE;
         end
      endcase
      // a new event wins over a clearing write
      next_s.evt = next_s.evt | evt_set;
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s <= '0;
         s.st <= ST_IDLE;
         s.sr <= SR_RESET;
      end else begin
         s <= next_s;
      end
   end
endmodule : exception_stacking_vectoring

// *** dv/exception_stacking_vectoring_asserts.sv ***
module exc_checker
   import exc_unit_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic mem_req_o,
   input wire logic mem_we_o,
   input wire logic mem_long_o,
   input wire logic [2:0] mem_fc_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic mem_err_i,
   input wire logic exc_busy_o,
   input wire logic status_o,
   input wire logic refill_o,
   input wire logic new_pc_valid_o,
   input wire logic irq_waiting_flag_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!nrst_i);
   // ==========
   // memory port
   property p_hold; mem_req_o && !mem_ack_i && !mem_err_i |=>
      mem_req_o && $stable(mem_addr_o) && $stable(mem_fc_o) && $stable(mem_we_o); endproperty
   a_hold: assert property (p_hold) else $error("request changed before ack");
   property p_gap; mem_req_o && (mem_ack_i || mem_err_i) |=> !mem_req_o; endproperty
   a_gap: assert property (p_gap) else $error("request not released");
   property p_vec_long; mem_req_o && !mem_we_o && mem_fc_o == FC_SUPER_DATA |-> mem_long_o;
   endproperty
   a_vec_long: assert property (p_vec_long) else $error("vector read not 32 bit");
   property p_frame_word; mem_req_o && mem_we_o |-> !mem_long_o && mem_fc_o == FC_SUPER_DATA;
   endproperty
   a_frame_word: assert property (p_frame_word) else $error("bad frame write");
   property p_iack; mem_req_o && mem_fc_o == FC_CPU_SPACE |->
      !mem_we_o && mem_addr_o[31:4] == IACK_ADDR_HI && mem_addr_o[0]; endproperty
   a_iack: assert property (p_iack) else $error("bad acknowledge cycle");
   // ==========
   // sequencer outputs
   property p_accept; $rose(exc_busy_o) |-> status_o; endproperty
   a_accept: assert property (p_accept) else $error("no status at accept");
   property p_new_pc; new_pc_valid_o |-> refill_o && !exc_busy_o; endproperty
   a_new_pc: assert property (p_new_pc) else $error("no refill with new pc");
   property p_wait; irq_waiting_flag_o && !exc_busy_o |-> ##[0:3] exc_busy_o; endproperty
   a_wait: assert property (p_wait) else $error("waiting request not taken");
endmodule : exc_checker

bind exception_stacking_vectoring exc_checker i_exc_checker (.clk_sys_i, .nrst_i, .mem_req_o,
   .mem_we_o, .mem_long_o, .mem_fc_o, .mem_addr_o, .mem_ack_i, .mem_err_i, .exc_busy_o,
   .status_o, .refill_o, .new_pc_valid_o, .irq_waiting_flag_o);

// *** dv/exc_far_side.sv ***
module exc_far_side
   import exc_unit_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic mem_req_i,
   input wire logic [2:0] mem_fc_i,
   input wire logic [31:0] mem_addr_i,
   input wire logic [1:0] dly_i,
   input wire logic autov_i,
   input wire logic [7:0] vec_i,
   input wire logic [2:0] level_i,
   output logic mem_ack_o,
   output logic [31:0] mem_rdata_o,
   output logic autov_o,
   output logic [2:0] level_o
);
   logic [1:0] cnt;
   assign level_o = level_i;
   // ==========
   // memory and acknowledge responder
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt <= 2'h0;
         mem_ack_o <= 1'h0;
         autov_o <= 1'h0;
         mem_rdata_o <= 32'h0;
      end else begin
         mem_ack_o <= 1'h0;
         autov_o <= 1'h0;
         mem_rdata_o <= ~mem_rdata_o;
         if (!mem_req_i || mem_ack_o) begin
            cnt <= 2'h0;
         end else if (cnt != dly_i) begin
            cnt <= cnt + 2'h1;
         end else begin
            mem_ack_o <= 1'h1;
            autov_o <= autov_i && mem_fc_i == FC_CPU_SPACE;
            mem_rdata_o <= mem_fc_i == FC_CPU_SPACE ? {24'h0, vec_i} : mem_addr_i ^ 32'h5A5A0000;
         end
      end
   end
endmodule : exc_far_side

// *** dv/test_exception_stacking_vectoring.sv ***
module test_exception_stacking_vectoring
   import exc_unit_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'h0, nrst_i = 1'h0, exc_req_i = 1'h0, insn_boundary_i = 1'h0, pavec = 1'h0;
   logic awvalid_i = 1'h0, wvalid_i = 1'h0, bready_i = 1'h0, arvalid_i = 1'h0, rready_i = 1'h0;
   logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00, exc_vector_i = 8'h00, pvec = 8'h00;
   logic [31:0] wdata_i = 32'h0, exc_pc_i = 32'h0, vtb, mstk, istk;
   logic [31:0] rdata_o, mem_rdata_i, mem_addr_o, new_pc_o;
   logic [1:0] exc_kind_i = 2'h0, exc_point_i = 2'h0, pdly = 2'h0, bresp_o, rresp_o;
   logic [2:0] plev = 3'h0, irq_level_inputs_i, mem_fc_o;
   logic [15:0] mem_wdata_o;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, exc_busy_o, irq_waiting_flag_o;
   logic auto_vector_request_i, mem_req_o, mem_we_o, mem_long_o, mem_ack_i;
   logic new_pc_valid_o, status_o, refill_o, irq_o;
   logic [33:0] q_rd[$], q_pc[$], q_fw[$];
   logic [5:0] fb[4] = '{6'h08, 6'h0C, 6'h14, 6'h20};
   int n_errors = 0, checks = 0, cycles = 0, nw = 0;

   exception_stacking_vectoring i_exception_stacking_vectoring (
      .clk_sys_i, .nrst_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i(4'hF),
      .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o,
      .rdata_o, .rresp_o, .rvalid_o, .rready_i, .exc_req_i, .exc_kind_i, .exc_vector_i,
      .exc_point_i, .exc_pc_i, .exc_busy_o, .irq_level_inputs_i, .auto_vector_request_i,
      .irq_waiting_flag_o, .mem_req_o, .mem_we_o, .mem_long_o, .mem_fc_o, .mem_addr_o,
      .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .mem_err_i(1'h0), .insn_boundary_i, .new_pc_o,
      .new_pc_valid_o, .status_o, .refill_o, .irq_o);
   exc_far_side i_exc_far_side (
      .clk_sys_i, .nrst_i, .mem_req_i(mem_req_o), .mem_fc_i(mem_fc_o), .mem_addr_i(mem_addr_o),
      .dly_i(pdly), .autov_i(pavec), .vec_i(pvec), .level_i(plev), .mem_ack_o(mem_ack_i),
      .mem_rdata_o(mem_rdata_i), .autov_o(auto_vector_request_i), .level_o(irq_level_inputs_i));

   // ==========
   // clock, watchdog, monitor
   initial begin
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      insn_boundary_i <= 1'($urandom);
      cycles++;
      if (cycles == 20000) begin
         $display("[ERR] %0t timeout", $time);
         n_errors++;
         stop_test();
      end
   end
   always @(posedge clk_sys_i) begin
      if (rvalid_o && rready_i) begin
         cmp({rresp_o, rdata_o}, q_rd.pop_front());
      end
      if (new_pc_valid_o) begin
         cmp({2'h0, new_pc_o}, q_pc.pop_front());
      end
      if (!exc_busy_o) begin
         nw = 0;
      end
      // fourth frame word carries point and vector
      if (mem_req_o && mem_we_o && mem_ack_i) begin
         if (nw == 3) begin
            cmp({18'h0, mem_wdata_o}, q_fw.pop_front());
         end
         nw++;
      end
   end

   task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   function automatic logic [31:0] vpc(input logic [7:0] v);
      return (vtb + {22'h0, v, 2'h0}) ^ 32'h5A5A0000;
   endfunction : vpc

   // ==========
   // bus and sequence drivers
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta = 1'h0;
      logic tw = 1'h0;
      awaddr_i <= a;
      wdata_i <= d;
      awvalid_i <= 1'h1;
      wvalid_i <= 1'h1;
      bready_i <= 1'h1;
      do begin
         @(posedge clk_sys_i);
         ta = ta | awready_o;
         tw = tw | wready_o;
         if (ta) awvalid_i <= 1'h0;
         if (tw) wvalid_i <= 1'h0;
      end while (!(ta && tw));
      do @(posedge clk_sys_i); while (!bvalid_o);
      bready_i <= 1'h0;
      @(posedge clk_sys_i);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      q_rd.push_back({r, d});
      araddr_i <= a;
      arvalid_i <= 1'h1;
      rready_i <= 1'h1;
      do @(posedge clk_sys_i); while (!arready_o);
      arvalid_i <= 1'h0;
      do @(posedge clk_sys_i); while (!rvalid_o);
      rready_i <= 1'h0;
      @(posedge clk_sys_i);
   endtask : rd

   task automatic wait_busy(input logic b);
      do @(posedge clk_sys_i); while (exc_busy_o !== b);
   endtask : wait_busy

   task automatic exc(input logic [1:0] k, input logic [7:0] v, input logic [1:0] p);
      q_pc.push_back({2'h0, vpc(v)});
      if (k != KIND_RESET) begin
         q_fw.push_back({20'h0, p, 2'h0, v, 2'h0});
      end
      exc_kind_i <= k;
      exc_vector_i <= v;
      exc_point_i <= p;
      exc_pc_i <= $urandom;
      pdly <= 2'($urandom);
      exc_req_i <= 1'h1;
      wait_busy(1'h1);
      exc_req_i <= 1'h0;
      wait_busy(1'h0);
   endtask : exc

   task automatic stop_test();
      if (n_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // ==========
   // scenarios
   initial begin
      logic [7:0] v;
      v = 8'($urandom(78));
      repeat (16) @(posedge clk_sys_i);
      nrst_i <= 1'h1;
      @(posedge clk_sys_i);
      rd(REG_SR, 32'h00002700);
      rd(8'h20, 32'h0, RESP_SLVERR);
      vtb = $urandom & 32'hFFFFFFFC;
      mstk = 32'h00008000;
      istk = 32'h00004000;
      wr(REG_VTB, vtb);
      wr(REG_MSTK, mstk);
      wr(REG_ISTK, istk);
      wr(REG_SR, 32'h0000D700);
      for (int p = 0; p < 4; p++) begin
         v = 8'($urandom_range(255, 32));
         exc(p[0] ? KIND_COPROC : KIND_INTERNAL, v, 2'(p));
         mstk -= fb[p];
         rd(REG_MSTK, mstk);
      end
      rd(REG_SR, 32'h00003700);
      rd(REG_ISTK, istk);
      wr(REG_MASK, 32'h7);
      pavec <= 1'h1;
      plev <= 3'h3;
      q_pc.push_back({2'h0, vpc(AUTOVEC_BASE + 8'h03)});
      q_fw.push_back({20'h0, exc_point_i, 2'h0, AUTOVEC_BASE + 8'h03, 2'h0});
      wr(REG_SR, 32'h00001000);
      wait_busy(1'h1);
      cmp({33'h0, irq_waiting_flag_o}, 34'h1);
      wait_busy(1'h0);
      cmp({33'h0, irq_waiting_flag_o}, 34'h0);
      mstk -= 8;
      istk -= 8;
      rd(REG_MSTK, mstk);
      rd(REG_ISTK, istk);
      rd(REG_SR, 32'h00002300);
      cmp({33'h0, irq_o}, 34'h1);
      wr(REG_MASK, 32'h0);
      cmp({33'h0, irq_o}, 34'h0);
      wr(REG_MASK, 32'h7);
      wr(REG_EVT, 32'h7);
      cmp({33'h0, irq_o}, 34'h0);
      v = 8'($urandom_range(255, 64));
      pvec <= v;
      pavec <= 1'h0;
      plev <= 3'h5;
      q_pc.push_back({2'h0, vpc(v)});
      q_fw.push_back({20'h0, exc_point_i, 2'h0, v, 2'h0});
      wait_busy(1'h1);
      cmp({33'h0, irq_waiting_flag_o}, 34'h1);
      wait_busy(1'h0);
      istk -= 8;
      rd(REG_ISTK, istk);
      rd(REG_SR, 32'h00002500);
      plev <= 3'h0;
      wr(REG_SR, 32'h00001000);
      exc(KIND_RESET, 8'h00, 2'h0);
      rd(REG_SR, 32'h00002700);
      rd(REG_ISTK, istk);
      stop_test();
   end
endmodule : test_exception_stacking_vectoring
